/* File: hdl/sfc_cmd.sv */
// Serial flash command front end: ident, param table, power-down, reset
`timescale 1ns/100ps

module sfc_cmd #(
  parameter int RELEASE_CYCLES = sfc_pkg::RELEASE_DELAY_CYCLES,
  parameter int BUF_DEPTH      = 2
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        csN,
  input  wire logic        sclk,
  input  wire logic [3:0]  ioIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOe,
  input  wire logic        writeInProgress,
  input  wire logic [7:0]  volatileConfig2,
  input  wire logic        readProtectLocked,
  input  wire logic        pageSize512,
  output logic             writeLatchFlag,
  output logic             deepPowerDown,
  output logic             softReset,
  output logic      [23:0] tableAddr,
  output logic             tableSel,
  input  wire logic [7:0]  tableData,
  output logic      [23:0] opAddr,
  output logic             eraseReq,
  output logic      [1:0]  eraseKind,
  output logic             progStart,
  output logic             progEnd,
  output logic      [9:0]  progCount,
  output logic             progOverrun,
  output logic             progValid,
  output logic      [7:0]  progData,
  input  wire logic        progReady
);

  localparam int RW = $clog2(RELEASE_CYCLES + 1);
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  typedef struct packed {
    sfc_pkg::sfc_state_e          st;
    logic [7:0]                   shift;
    logic [3:0]                   bitCnt;
    logic [7:0]                   opcode;
    logic [1:0]                   addrCnt;
    logic [3:0]                   dummyCnt;
    logic                         quad;
    logic [7:0]                   outByte;
    logic [3:0]                   outCnt;
    logic                         tblSel;
    logic [23:0]                  tblAddr;
    logic [23:0]                  opAddr;
    logic [9:0]                   progCnt;
    logic                         progLive;
    logic                         overrun;
    logic                         write_latch_flag;
    logic                         deep_power_down;
    logic                         rstArm;
    logic [RW-1:0]                relCnt;
    logic [3:0]                   ioOut;
    logic [3:0]                   ioOe;
    logic                         softRst;
    logic                         eraseReq;
    logic [1:0]                   eraseKind;
    logic                         progStart;
    logic                         progEnd;
    logic [BUF_DEPTH-1:0][7:0]    bufData;
    logic [PW:0]                  bufCnt;
    logic [PW-1:0]                rdPtr;
    logic                         csS1;
    logic                         csS2;
    logic                         csD;
    logic                         ckS1;
    logic                         ckS2;
    logic                         ckD;
    logic [3:0]                   ioS1;
    logic [3:0]                   ioS2;
  } sfc_state_s;

  sfc_state_s r;
  sfc_state_s next_r;

  // Outputs straight from the state register
  assign ioOut          = r.ioOut;
  assign ioOe           = r.ioOe;
  assign writeLatchFlag = r.write_latch_flag;
  assign deepPowerDown  = r.deep_power_down;
  assign softReset      = r.softRst;
  assign tableAddr      = r.tblAddr;
  assign tableSel       = r.tblSel;
  assign opAddr         = r.opAddr;
  assign eraseReq       = r.eraseReq;
  assign eraseKind      = r.eraseKind;
  assign progStart      = r.progStart;
  assign progEnd        = r.progEnd;
  assign progCount      = r.progCnt;
  assign progOverrun    = r.overrun;
  // Bytes leave as clear masks; the array engine only moves ones to zero
  assign progValid      = (r.bufCnt != '0);
  assign progData       = r.bufData[r.rdPtr];

  // Next-state logic for the whole command front end
  always_comb begin
    logic        csRise;
    logic        ckRise;
    logic        ckFall;
    logic        byteDone;
    logic        push;
    logic        pop;
    logic [7:0]  inByte;
    logic [3:0]  cnt;
    logic [7:0]  cur;
    logic [9:0]  pageLimit;
    logic [PW-1:0] wrIdx;
    csRise    = r.csS2 && !r.csD;
    ckRise    = !r.csS2 && r.ckS2 && !r.ckD;
    ckFall    = !r.csS2 && !r.ckS2 && r.ckD;
    byteDone  = 1'b0;
    push      = 1'b0;
    pop       = progValid && progReady;
    inByte    = '0;
    cnt       = '0;
    cur       = '0;
    pageLimit = pageSize512 ? 10'(sfc_pkg::PAGE_LARGE)
                            : 10'(sfc_pkg::PAGE_SMALL);
    wrIdx     = PW'(r.rdPtr + r.bufCnt[PW-1:0]);
    next_r    = r;
    next_r.softRst   = 1'b0;
    next_r.eraseReq  = 1'b0;
    next_r.progStart = 1'b0;
    next_r.progEnd   = 1'b0;

    // Two-flop synchronisers; edges come from the second stage only
    next_r.csS1 = csN;
    next_r.csS2 = r.csS1;
    next_r.csD  = r.csS2;
    next_r.ckS1 = sclk;
    next_r.ckS2 = r.ckS1;
    next_r.ckD  = r.ckS2;
    next_r.ioS1 = ioIn;
    next_r.ioS2 = r.ioS1;

    // Lane width follows the config bit only between frames
    if (r.csS2) begin
      next_r.quad = volatileConfig2[sfc_pkg::QUAD_CFG_BIT];
    end

    // Release delay: stay powered down until the count runs out
    if (r.relCnt != '0) begin
      next_r.relCnt = RW'(r.relCnt - 1'b1);
      if (r.relCnt == RW'(1)) begin
        next_r.deep_power_down = 1'b0;
      end
    end

    if (csRise) begin
      // Frame end: ident and table output stop here
      next_r.st      = sfc_pkg::ST_OPCODE;
      next_r.bitCnt  = '0;
      next_r.addrCnt = '0;
      next_r.outCnt  = '0;
      next_r.ioOe    = '0;
      if (r.progLive) begin
        next_r.progLive = 1'b0;
        next_r.progEnd  = 1'b1;
      end
      if (r.st == sfc_pkg::ST_WAIT_END && r.bitCnt == '0) begin
        next_r.rstArm = 1'b0;
        case (r.opcode)
          sfc_pkg::OP_WRITE_ENABLE: begin
            next_r.write_latch_flag = 1'b1;
          end
          sfc_pkg::OP_WRITE_DISABLE: begin
            if (!writeInProgress) begin
              next_r.write_latch_flag = 1'b0;
            end
          end
          sfc_pkg::OP_DEEP_PD: begin
            if (!writeInProgress) begin
              next_r.deep_power_down = 1'b1;
            end
          end
          sfc_pkg::OP_RELEASE_PD: begin
            next_r.relCnt = RW'(RELEASE_CYCLES);
          end
          sfc_pkg::OP_RESET_ENABLE: begin
            next_r.rstArm = 1'b1;
          end
          sfc_pkg::OP_RESET, sfc_pkg::OP_LEGACY_RESET: begin
            if (r.rstArm || r.opcode == sfc_pkg::OP_LEGACY_RESET) begin
              // Freeze and lock bits live outside and ignore this pulse
              next_r.softRst = 1'b1;
              next_r.write_latch_flag     = sfc_pkg::WEL_RESET;
              next_r.deep_power_down     = sfc_pkg::DPD_RESET;
              next_r.relCnt  = '0;
              next_r.overrun = 1'b0;
              next_r.bufCnt  = '0;
              next_r.rdPtr   = '0;
              next_r.progCnt = '0;
              next_r.progEnd = 1'b0;
              pop            = 1'b0;
            end
          end
          sfc_pkg::OP_BULK_ERASE, sfc_pkg::OP_SECTOR_ERASE,
          sfc_pkg::OP_PARAM_ERASE: begin
            if (r.write_latch_flag && !writeInProgress) begin
              // The engine sets the whole selected region to ones
              next_r.eraseReq  = 1'b1;
              next_r.write_latch_flag       = 1'b0;
              next_r.eraseKind =
                (r.opcode == sfc_pkg::OP_BULK_ERASE)  ? sfc_pkg::ERASE_BULK :
                (r.opcode == sfc_pkg::OP_PARAM_ERASE) ? sfc_pkg::ERASE_PARAM :
                                                        sfc_pkg::ERASE_SECTOR;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (ckRise) begin
      // Shift in one bit, or one nibble in quad-all mode
      if (r.st == sfc_pkg::ST_OPCODE || r.st == sfc_pkg::ST_ADDR ||
          r.st == sfc_pkg::ST_PROG_DATA) begin
        if (r.quad) begin
          inByte = {r.shift[3:0], r.ioS2};
          cnt    = r.bitCnt + 4'h4;
        end else begin
          inByte = {r.shift[6:0], r.ioS2[0]};
          cnt    = r.bitCnt + 4'h1;
        end
        next_r.shift = inByte;
        byteDone     = (cnt == 4'h8);
        next_r.bitCnt = byteDone ? 4'h0 : cnt;
      end
      case (r.st)
        sfc_pkg::ST_OPCODE: begin
          if (byteDone) begin
            next_r.opcode = inByte;
            if (r.deep_power_down) begin
              next_r.st = (inByte == sfc_pkg::OP_RELEASE_PD &&
                           r.relCnt == '0) ? sfc_pkg::ST_WAIT_END
                                           : sfc_pkg::ST_IGNORE;
            end else begin
              case (inByte)
                sfc_pkg::OP_READ_IDENT, sfc_pkg::OP_READ_QUAD_IDENT: begin
                  if (writeInProgress ||
                      (inByte == sfc_pkg::OP_READ_QUAD_IDENT && !r.quad))
                  begin
                    next_r.st = sfc_pkg::ST_IGNORE;
                  end else begin
                    next_r.st      = sfc_pkg::ST_OUTPUT;
                    next_r.tblSel  = 1'b0;
                    next_r.tblAddr = sfc_pkg::TABLE_START;
                  end
                end
                sfc_pkg::OP_READ_PARAM: begin
                  next_r.st = readProtectLocked ? sfc_pkg::ST_IGNORE
                                                : sfc_pkg::ST_ADDR;
                end
                sfc_pkg::OP_PAGE_PROGRAM, sfc_pkg::OP_SECTOR_ERASE,
                sfc_pkg::OP_PARAM_ERASE: begin
                  next_r.st = (r.write_latch_flag && !writeInProgress)
                              ? sfc_pkg::ST_ADDR
                              : sfc_pkg::ST_IGNORE;
                end
                sfc_pkg::OP_BULK_ERASE, sfc_pkg::OP_WRITE_ENABLE,
                sfc_pkg::OP_WRITE_DISABLE, sfc_pkg::OP_DEEP_PD,
                sfc_pkg::OP_RELEASE_PD, sfc_pkg::OP_RESET_ENABLE,
                sfc_pkg::OP_RESET, sfc_pkg::OP_LEGACY_RESET: begin
                  next_r.st = sfc_pkg::ST_WAIT_END;
                end
                default: begin
                  next_r.st = sfc_pkg::ST_IGNORE;
                end
              endcase
            end
          end
        end
        sfc_pkg::ST_ADDR: begin
          if (byteDone) begin
            next_r.opAddr  = {r.opAddr[15:0], inByte};
            next_r.addrCnt = r.addrCnt + 2'h1;
            // Three bytes always, whatever the array address length
            if (r.addrCnt == 2'(sfc_pkg::PARAM_ADDR_BYTES - 1)) begin
              next_r.dummyCnt = '0;
              if (r.opcode == sfc_pkg::OP_READ_PARAM) begin
                next_r.st = sfc_pkg::ST_DUMMY;
              end else if (r.opcode == sfc_pkg::OP_PAGE_PROGRAM) begin
                next_r.st        = sfc_pkg::ST_PROG_DATA;
                next_r.progStart = 1'b1;
                next_r.progLive  = 1'b1;
                next_r.progCnt   = '0;
                next_r.overrun   = 1'b0;
                next_r.write_latch_flag       = 1'b0;
              end else begin
                next_r.st = sfc_pkg::ST_WAIT_END;
              end
            end
          end
        end
        sfc_pkg::ST_DUMMY: begin
          next_r.dummyCnt = r.dummyCnt + 4'h1;
          if (r.dummyCnt == sfc_pkg::PARAM_DUMMY_CYCLES - 4'h1) begin
            next_r.st      = sfc_pkg::ST_OUTPUT;
            next_r.tblSel  = 1'b1;
            next_r.tblAddr = r.opAddr;
          end
        end
        sfc_pkg::ST_PROG_DATA: begin
          // Bytes past the page size are dropped, not wrapped
          if (byteDone && r.progCnt < pageLimit) begin
            next_r.progCnt = r.progCnt + 10'h1;
            if (r.bufCnt < (PW+1)'(BUF_DEPTH) || pop) begin
              push = 1'b1;
            end else begin
              next_r.overrun = 1'b1;
            end
          end
        end
        sfc_pkg::ST_WAIT_END: begin
          next_r.st = sfc_pkg::ST_IGNORE;
        end
        default: begin
        end
      endcase
    end else if (ckFall && r.st == sfc_pkg::ST_OUTPUT) begin
      // Drive MSB first; a new byte is fetched at each byte start
      cur = (r.outCnt == '0) ? tableData : r.outByte;
      if (r.quad) begin
        next_r.ioOut   = cur[7:4];
        next_r.ioOe    = 4'hf;
        next_r.outByte = {cur[3:0], 4'h0};
        cnt            = r.outCnt + 4'h4;
      end else begin
        next_r.ioOut   = {2'b00, cur[7], 1'b0};
        next_r.ioOe    = 4'h2;
        next_r.outByte = {cur[6:0], 1'b0};
        cnt            = r.outCnt + 4'h1;
      end
      if (cnt == 4'h8) begin
        next_r.outCnt  = '0;
        next_r.tblAddr = r.tblAddr + 24'h1;
      end else begin
        next_r.outCnt = cnt;
      end
    end

    // Two-entry buffer between the link and the array engine
    if (push) begin
      next_r.bufData[wrIdx] = inByte;
    end
    if (pop) begin
      next_r.rdPtr = PW'(r.rdPtr + 1'b1);
    end
    next_r.bufCnt = (PW+1)'(r.bufCnt + {{PW{1'b0}}, push}
                    - {{PW{1'b0}}, pop});
  end

  // State register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r      <= '0;
      r.csS1 <= 1'b1;
      r.csS2 <= 1'b1;
      r.csD  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_dpd_idle;
    $rose(deepPowerDown) |-> !$past(writeInProgress);
  endproperty
  a_dpd_idle: assert property (p_dpd_idle)
    else $error("power-down entered while busy");

  property p_dpd_deaf;
    deepPowerDown && r.relCnt == '0 |=> !$rose(writeLatchFlag) && !softReset;
  endproperty
  a_dpd_deaf: assert property (p_dpd_deaf)
    else $error("command obeyed in power-down");

  property p_release_delay;
    $fell(deepPowerDown) |-> $past(r.relCnt) == RW'(1) && !softReset;
  endproperty
  a_release_delay: assert property (p_release_delay)
    else $error("power-down left without release delay");

  property p_prog_needs_wel;
    progStart |-> $past(writeLatchFlag) && !writeLatchFlag;
  endproperty
  a_prog_needs_wel: assert property (p_prog_needs_wel)
    else $error("program started without write enable");

  property p_erase_needs_wel;
    eraseReq |-> $past(writeLatchFlag) && !$past(writeInProgress);
  endproperty
  a_erase_needs_wel: assert property (p_erase_needs_wel)
    else $error("erase issued without write enable");

  property p_ident_not_busy;
    r.st == sfc_pkg::ST_OUTPUT && $past(r.st) != sfc_pkg::ST_OUTPUT &&
      !tableSel |-> !$past(writeInProgress) && tableAddr == '0;
  endproperty
  a_ident_not_busy: assert property (p_ident_not_busy)
    else $error("ident read started while busy");

  property p_quad_ident;
    r.st == sfc_pkg::ST_OUTPUT && $past(r.st) != sfc_pkg::ST_OUTPUT &&
      r.opcode == sfc_pkg::OP_READ_QUAD_IDENT |-> r.quad;
  endproperty
  a_quad_ident: assert property (p_quad_ident)
    else $error("quad ident served outside quad-all mode");

  property p_wel_set;
    $rose(writeLatchFlag) |-> $past(r.opcode) == sfc_pkg::OP_WRITE_ENABLE;
  endproperty
  a_wel_set: assert property (p_wel_set)
    else $error("write latch set by another command");

  property p_soft_reset;
    softReset |-> !writeLatchFlag && !deepPowerDown && !progValid;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset left state behind");

  property p_page_limit;
    progCount <= (pageSize512 ? 10'(sfc_pkg::PAGE_LARGE)
                              : 10'(sfc_pkg::PAGE_SMALL)) || !r.progLive;
  endproperty
  a_page_limit: assert property (p_page_limit)
    else $error("page program beyond page size");

  property p_oe_width;
    $rose(ioOe[1]) |-> ioOe == (r.quad ? 4'hf : 4'h2) &&
      r.st == sfc_pkg::ST_OUTPUT;
  endproperty
  a_oe_width: assert property (p_oe_width)
    else $error("output lanes do not match mode");

endmodule : sfc_cmd

/* File: hdl/sfc_pkg.sv */
// Opcodes, timing counts and state encoding for the flash command front end
package sfc_pkg;

  // Instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
  localparam logic [7:0] OP_READ_IDENT      = 8'h9f;
  localparam logic [7:0] OP_READ_QUAD_IDENT = 8'haf;
  localparam logic [7:0] OP_READ_PARAM      = 8'h5a;
  localparam logic [7:0] OP_DEEP_PD         = 8'hb9;
  localparam logic [7:0] OP_RELEASE_PD      = 8'hab;
  localparam logic [7:0] OP_RESET_ENABLE    = 8'h66;
  localparam logic [7:0] OP_RESET           = 8'h99;
  localparam logic [7:0] OP_LEGACY_RESET    = 8'hf0;
  localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE    = 8'hd8;
  localparam logic [7:0] OP_PARAM_ERASE     = 8'h20;
  localparam logic [7:0] OP_BULK_ERASE      = 8'h60;

  // Erase scope handed to the array engine
  localparam logic [1:0] ERASE_SECTOR = 2'h0;
  localparam logic [1:0] ERASE_PARAM  = 2'h1;
  localparam logic [1:0] ERASE_BULK   = 2'h2;

  // Status and configuration bit positions
  localparam int WIP_BIT      = 0;
  localparam int WEL_BIT      = 1;
  localparam int QUAD_CFG_BIT = 6;

  // Frame layout of the parameter-table read
  localparam int        PARAM_ADDR_BYTES   = 3;
  localparam logic [3:0] PARAM_DUMMY_CYCLES = 4'h8;
  localparam logic [23:0] TABLE_START      = 24'h000000;

  // Page sizes
  localparam int PAGE_SMALL = 256;
  localparam int PAGE_LARGE = 512;

  // Reset values of the latches
  localparam logic WEL_RESET = 1'b0;
  localparam logic DPD_RESET = 1'b0;

  // Release delay
  localparam int MCLK_FREQ_MHZ        = 100;
  localparam int RELEASE_DELAY_NS     = 3000;
  localparam int RELEASE_DELAY_CYCLES =
    (RELEASE_DELAY_NS * MCLK_FREQ_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_OUTPUT,
    ST_PROG_DATA,
    ST_WAIT_END,
    ST_IGNORE
  } sfc_state_e;

endpackage : sfc_pkg

/* File: bench/sfc_host.sv */
// Host controller model driving the serial flash link
`timescale 1ns/100ps
module sfc_host (
  output logic            csN,
  output logic            sclk,
  output logic      [3:0] ioIn,
  input  wire logic [3:0] ioOut
);
  logic quad;
  // Idle: deselected, mode 0 clock low
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    ioIn = 4'h0;
    quad = 1'b0;
  end
  // Select the device; offset keeps link edges off the system clock
  task automatic start();
    #1.3;
    csN = 1'b0;
    #62.5;
  endtask : start
  // Deselect half a clock after the last fall; released lines flip
  task automatic stop();
    #62.5;
    csN = 1'b1;
    ioIn = ~ioIn;
    #500;
  endtask : stop
  // One 125 ns clock, well under the read ceiling; sample on the rise
  task automatic clk(input logic [3:0] d, output logic [3:0] q);
    ioIn = d;
    #62.5;
    sclk = 1'b1;
    q = ioOut;
    #62.5;
    sclk = 1'b0;
  endtask : clk
  // One byte each way, MSB first; quad as two nibbles
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic [3:0] r;
    if (quad) begin
      clk(d[7:4], r);
      q[7:4] = r;
      clk(d[3:0], r);
      q[3:0] = r;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        clk({~d[i], ~d[i], ~d[i], d[i]}, r);
        q[i] = r[1];
      end
    end
  endtask : xfer
endmodule : sfc_host

/* File: bench/sfc_cmd_tb.sv */
// Self-checking bench of the flash command front end
`timescale 1ns/100ps
module sfc_cmd_tb;
  logic        mclk, resetn, write_in_progress, rpl, rdy, stall, oeSeen, psz;
  logic        write_latch_flag, deep_power_down, srst, tsel, ereq, pst, pend, povr, pval;
  logic [3:0]  ioOut, ioOe, ioIn;
  logic        csN, sclk;
  logic [7:0]  cfg, tdat, pdat;
  logic [23:0] taddr, oaddr;
  logic [1:0]  ekind;
  logic [9:0]  pcnt;
  logic [7:0]  got[$];
  int          nSoft, nErase, nStart, nEnd, n_fail, samples_checked;
  // A lane the device does not drive reads as the inverse of its last value
  sfc_host host (.csN(csN), .sclk(sclk), .ioIn(ioIn),
    .ioOut(ioOut ^ ~ioOe));
  sfc_cmd #(.RELEASE_CYCLES(5)) uut (.mclk(mclk), .resetn(resetn),
    .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .writeInProgress(write_in_progress), .volatileConfig2(cfg), .readProtectLocked(rpl),
    .pageSize512(psz), .writeLatchFlag(write_latch_flag), .deepPowerDown(deep_power_down),
    .softReset(srst), .tableAddr(taddr), .tableSel(tsel), .tableData(tdat),
    .opAddr(oaddr), .eraseReq(ereq), .eraseKind(ekind), .progStart(pst),
    .progEnd(pend), .progCount(pcnt), .progOverrun(povr), .progValid(pval),
    .progData(pdat), .progReady(rdy));
  // Table contents as a function of place and table
  function automatic logic [7:0] tbl(input logic s, input logic [23:0] a);
    return {a[5:0], s, a[6]} ^ 8'h3c;
  endfunction : tbl
  // Page size in bytes selected by the size input
  function automatic int pageLim(input logic p);
    return p ? sfc_pkg::PAGE_LARGE : sfc_pkg::PAGE_SMALL;
  endfunction : pageLim
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Table port, pulse counters, consumer with random stalls
  always @(posedge mclk) begin
    tdat <= tbl(tsel, taddr);
    nSoft += srst;
    nErase += ereq;
    nStart += pst;
    nEnd += pend;
    if (ioOe !== 4'h0) oeSeen = 1'b1;
    if (pval && rdy) got.push_back(pdat);
  end
  always @(negedge mclk) rdy <= stall ? 1'b0 : 1'($urandom);
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op);
    logic [7:0] q;
    @(negedge mclk);
    host.start();
    host.xfer(op, q);
    host.stop();
  endtask : cmd
  // Table read: ident or param table, checked or expected silent
  task automatic rd(input logic [7:0] op, input logic s, input int n,
                    input logic ok);
    logic [7:0] q;
    logic [3:0] r;
    logic [23:0] a = s ? 24'($urandom & 24'h3f) : 24'h0;
    oeSeen = 1'b0;
    @(negedge mclk);
    host.start();
    host.xfer(op, q);
    if (s) begin
      for (int i = 2; i >= 0; i--) host.xfer(a[8*i+:8], q);
      for (int i = 0; i < 8; i++) host.clk(4'h0, r);
    end
    for (int i = 0; i < n; i++) begin
      host.xfer(8'h00, q);
      if (ok) chk(q, tbl(s, a + 24'(i)));
    end
    host.stop();
    chk(ioOe, 4'h0);
    if (!ok) chk(oeSeen, 1'b0);
    $display("test done read %h", op);
  endtask : rd
  // Page program with n random bytes; st holds the consumer off
  task automatic prog(input int n, input logic en, input logic st);
    logic [7:0] q, b, d[$];
    int s = nStart;
    int f = nEnd;
    int e = (n < pageLim(psz)) ? n : pageLim(psz);
    got = {};
    stall = st;
    @(negedge mclk);
    host.start();
    host.xfer(8'h02, q);
    for (int i = 0; i < 3; i++) host.xfer(8'($urandom), q);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      d.push_back(b);
      host.xfer(b, q);
    end
    host.stop();
    stall = 1'b0;
    #300;
    chk(24'(nStart - s), 24'(en));
    chk(24'(nEnd - f), 24'(en));
    if (en) begin
      chk(povr, st);
      if (!st) chk(pcnt, 24'(e));
      chk(24'(got.size()), st ? 24'd2 : 24'(e));
      foreach (got[i]) chk(got[i], d[i]);
    end
    $display("test done program");
  endtask : prog
  // Erase of one kind at a random address, none sent for bulk 8'h60; en says the latch was set
  task automatic ers(input logic [7:0] op, input logic [1:0] k,
                     input logic en);
    logic [7:0] q;
    logic [23:0] a = 24'($urandom);
    int e = nErase;
    @(negedge mclk);
    host.start();
    host.xfer(op, q);
    if (op != 8'h60) begin
      for (int i = 2; i >= 0; i--) host.xfer(a[8*i+:8], q);
    end
    host.stop();
    chk(24'(nErase - e), 24'(en));
    if (en) begin
      chk(24'(ekind), 24'(k));
      if (op != 8'h60) chk(oaddr, a);
    end
    $display("test done erase %h", op);
  endtask : ers
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    #1000000;
    n_fail++;
    test_done();
  end
  initial begin
    void'($urandom(32'h72c678ae));
    {resetn, write_in_progress, rpl, stall, oeSeen, psz, cfg} = '0;
    {nSoft, nErase, nStart, nEnd, n_fail, samples_checked} = '0;
    repeat (4) @(posedge mclk);
    @(negedge mclk) resetn = 1'b1;
    #100;
    rd(8'h9f, 0, 5, 1);
    rd(8'h5a, 1, 3, 1);
    rd(8'haf, 0, 2, 0);
    @(negedge mclk) rpl = 1'b1;
    rd(8'h5a, 1, 2, 0);
    @(negedge mclk) {rpl, write_in_progress} = 2'b01;
    rd(8'h9f, 0, 2, 0);
    cmd(8'hb9);
    chk(deep_power_down, 1'b0);
    @(negedge mclk) {write_in_progress, cfg, psz} = {1'b0, 8'h40, 1'($urandom)};
    host.quad = 1'b1;
    rd(8'h9f, 0, 3, 1);
    rd(8'haf, 0, 3, 1);
    rd(8'h5a, 1, 2, 1);
    cmd(8'h06);
    prog(pageLim(psz) + 1, 1, 0);
    host.quad = 1'b0;
    @(negedge mclk) cfg = 8'h00;
    cmd(8'h06);
    chk(write_latch_flag, 1'b1);
    cmd(8'h04);
    chk(write_latch_flag, 1'b0);
    cmd(8'h06);
    rd(8'h00, 0, 1, 0);
    chk(write_latch_flag, 1'b1);
    cmd(8'h99);
    chk(24'(nSoft), 24'd0);
    cmd(8'h66);
    cmd(8'h99);
    chk(write_latch_flag, 1'b0);
    chk(24'(nSoft), 24'd1);
    cmd(8'hf0);
    chk(24'(nSoft), 24'd2);
    prog(2, 0, 0);
    cmd(8'h06);
    prog(1 + $urandom_range(5), 1, 0);
    cmd(8'h06);
    prog(4, 1, 1);
    ers(8'hd8, sfc_pkg::ERASE_SECTOR, 1'b0);
    cmd(8'h06);
    ers(8'hd8, sfc_pkg::ERASE_SECTOR, 1'b1);
    cmd(8'h06);
    ers(8'h20, sfc_pkg::ERASE_PARAM, 1'b1);
    cmd(8'h06);
    ers(8'h60, sfc_pkg::ERASE_BULK, 1'b1);
    cmd(8'hb9);
    chk(deep_power_down, 1'b1);
    rd(8'h9f, 0, 2, 0);
    cmd(8'h06);
    chk(write_latch_flag, 1'b0);
    cmd(8'hab);
    chk(deep_power_down, 1'b0);
    test_done();
  end
endmodule : sfc_cmd_tb
